// >>> core/sbrtc_pkg.sv
// Purpose: Shared constants and types of the serial BCD real-time clock core.
// Assumes: A 100 MHz system clock and a 32.768 kHz crystal clock.
// Notes:   Register indices follow the sequential access order of the store.
package sbrtc_pkg;
    localparam int          REG_COUNT    = 8;
    localparam logic [6:0]  SLAVE_ADDR7  = 7'h68;
    localparam logic [2:0]  REG_SEC      = 3'h0;
    localparam logic [2:0]  REG_MIN      = 3'h1;
    localparam logic [2:0]  REG_HOUR     = 3'h2;
    localparam logic [2:0]  REG_DAY      = 3'h3;
    localparam logic [2:0]  REG_DATE     = 3'h4;
    localparam logic [2:0]  REG_MONTH    = 3'h5;
    localparam logic [2:0]  REG_YEAR     = 3'h6;
    localparam logic [2:0]  REG_CAL      = 3'h7;
    localparam int          HOUR_CEB_BIT = 7;
    localparam int          HOUR_CB_BIT  = 6;
    localparam int          CAL_OUT_BIT  = 7;
    localparam int          CAL_FREQ_BIT = 6;
    localparam logic [7:0]  RESET_ZERO   = 8'h00;
    localparam logic [7:0]  RESET_ONE    = 8'h01;
    localparam logic [7:0]  RESET_CAL    = 8'h80;
    localparam logic [7:0]  SEC_LAST     = 8'h59;
    localparam logic [7:0]  HOUR_LAST    = 8'h23;
    localparam logic [7:0]  DAY_LAST     = 8'h07;
    localparam logic [7:0]  MONTH_LAST   = 8'h12;
    localparam logic [7:0]  YEAR_LAST    = 8'h99;
    localparam int          XTAL_HZ      = 32768;
    localparam logic [3:0]  BIT_COUNT    = 4'h8;

    typedef enum logic [2:0] {
        SQ_IDLE,
        SQ_RX,
        SQ_ACK_OUT,
        SQ_TX,
        SQ_ACK_IN
    } sbrtc_state_t;

    typedef enum logic [1:0] {
        K_ADDR,
        K_PTR,
        K_DATA
    } sbrtc_kind_t;
endpackage : sbrtc_pkg

// >>> core/sbrtc_core.sv
// Purpose: Two-wire bus slave with an eight-byte BCD clock/calendar store.
// Assumes: Bus pins and the power-fail level are asynchronous to I_CLOCK.
// Notes:   The crystal divider runs on its own clock; the seconds tick crosses as a toggle.

// Contract
// - Timekeeping is derived by dividing a 32.768 kHz crystal clock down to one tick per second.
// - On supply failure the calendar keeps counting without any help from the bus master.
// - The calendar lives in eight byte registers holding BCD fields.
// - The register pointer steps by one after every data byte, read or written.
// - The store holds century, year, month, date, weekday, 24-hour hours, minutes and seconds.
// - The date rolls over by month length with February 29 in leap years up to 2100.
// - Addresses and data move bit-serially on a two-wire bus clocked up to 400 kHz.
// - The frequency-test/output pin is only pulled low or released, never driven high.
// - The device answers only a start followed by slave address D0h; the code also acknowledges D1h for reads.
// - On power failure a transfer is aborted, the pointer reset and the bus ignored.
// - User copies freeze while the pointer is at 00h-06h and resume at stop or at 07h.
// - The pointer moves only on the acknowledge clock of a byte; the code loads a pointer byte at the eighth clock's fall.
module sbrtc_core #(
    parameter int XTAL_DIV = sbrtc_pkg::XTAL_HZ
) (
    input  wire logic I_CLOCK,
    input  wire logic I_RESET,
    input  wire logic I_XTAL_CLOCK,
    input  wire logic I_SCL,
    input  wire logic I_SDA_IN,
    output logic      O_SDA_OUT,
    output logic      O_SDA_OE,
    output logic      O_FREQ_PIN_OUT,
    output logic      O_FREQ_PIN_OE,
    input  wire logic I_POWER_FAIL,
    output logic      O_ON_BACKUP
);
    logic [15:0]                div_q;
    logic                       tog_x_q;
    logic [2:0]                 tog_q;
    logic [1:0]                 scl_m_q, sda_m_q, pf_m_q;
    logic                       scl_p_q, sda_p_q, pf_q;
    logic                       tick;
    logic                       scl_rise, scl_fall, start_c, stop_c;
    logic [7:0]                 live_q [sbrtc_pkg::REG_COUNT];
    logic [7:0]                 user_q [sbrtc_pkg::REG_COUNT];
    sbrtc_pkg::sbrtc_state_t    state_q;
    sbrtc_pkg::sbrtc_kind_t     kind_q;
    logic [3:0]                 cnt_q;
    logic [7:0]                 sh_q, tx_q;
    logic [2:0]                 ptr_q;
    logic                       rw_q, active_q, frozen_q, wr_en;
    logic                       sec_w, min_w, hr_w, day_w, date_w, mon_w, yr_w;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] >= 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    endfunction : bcd_inc

    function automatic logic leap(input logic [7:0] y);
        leap = (!y[4] && (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8)) ||
               (y[4] && (y[3:0] == 4'h2 || y[3:0] == 4'h6));
    endfunction : leap

    function automatic logic [7:0] month_len(input logic [7:0] m, input logic [7:0] y);
        case (m)
            8'h02:                      month_len = leap(y) ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
            default:                    month_len = 8'h31;
        endcase
    endfunction : month_len

    // Crystal divider: one toggle per second crosses to the system domain.
    always_ff @(posedge I_XTAL_CLOCK or posedge I_RESET) begin
        if (I_RESET) begin
            div_q   <= 16'h0000;
            tog_x_q <= 1'b0;
        end else if (div_q == 16'(XTAL_DIV - 1)) begin
            div_q   <= 16'h0000;
            tog_x_q <= ~tog_x_q;
        end else begin
            div_q <= div_q + 16'h0001;
        end
    end

    always_ff @(posedge I_CLOCK or posedge I_RESET) begin
        if (I_RESET) begin
            tog_q   <= 3'h0;
            scl_m_q <= 2'h3;
            sda_m_q <= 2'h3;
            pf_m_q  <= 2'h0;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            pf_q    <= 1'b0;
        end else begin
            tog_q   <= {tog_q[1:0], tog_x_q};
            scl_m_q <= {scl_m_q[0], I_SCL};
            sda_m_q <= {sda_m_q[0], I_SDA_IN};
            pf_m_q  <= {pf_m_q[0], I_POWER_FAIL};
            scl_p_q <= scl_m_q[1];
            sda_p_q <= sda_m_q[1];
            pf_q    <= pf_m_q[1];
        end
    end

    assign tick     = tog_q[2] ^ tog_q[1];
    assign scl_rise = scl_m_q[1] && !scl_p_q;
    assign scl_fall = !scl_m_q[1] && scl_p_q;
    assign start_c  = scl_m_q[1] && scl_p_q && sda_p_q && !sda_m_q[1];
    assign stop_c   = scl_m_q[1] && scl_p_q && !sda_p_q && sda_m_q[1];
    assign wr_en    = !pf_q && state_q == sbrtc_pkg::SQ_RX && kind_q == sbrtc_pkg::K_DATA
                      && cnt_q == sbrtc_pkg::BIT_COUNT && scl_fall;

    always_comb begin
        sec_w  = live_q[sbrtc_pkg::REG_SEC] == sbrtc_pkg::SEC_LAST;
        min_w  = sec_w && live_q[sbrtc_pkg::REG_MIN] == sbrtc_pkg::SEC_LAST;
        hr_w   = min_w && live_q[sbrtc_pkg::REG_HOUR][5:0] == sbrtc_pkg::HOUR_LAST[5:0];
        day_w  = live_q[sbrtc_pkg::REG_DAY] == sbrtc_pkg::DAY_LAST;
        date_w = hr_w && live_q[sbrtc_pkg::REG_DATE] ==
                 month_len(live_q[sbrtc_pkg::REG_MONTH], live_q[sbrtc_pkg::REG_YEAR]);
        mon_w  = date_w && live_q[sbrtc_pkg::REG_MONTH] == sbrtc_pkg::MONTH_LAST;
        yr_w   = mon_w && live_q[sbrtc_pkg::REG_YEAR] == sbrtc_pkg::YEAR_LAST;
    end

    // Counting registers; they keep running whatever the supply state.
    always_ff @(posedge I_CLOCK or posedge I_RESET) begin
        if (I_RESET) begin
            for (int i = 0; i < sbrtc_pkg::REG_COUNT; i++) begin
                live_q[i] <= sbrtc_pkg::RESET_ZERO;
            end
            live_q[sbrtc_pkg::REG_DAY]   <= sbrtc_pkg::RESET_ONE;
            live_q[sbrtc_pkg::REG_DATE]  <= sbrtc_pkg::RESET_ONE;
            live_q[sbrtc_pkg::REG_MONTH] <= sbrtc_pkg::RESET_ONE;
            live_q[sbrtc_pkg::REG_CAL]   <= sbrtc_pkg::RESET_CAL;
        end else begin
            if (tick) begin
                live_q[sbrtc_pkg::REG_SEC] <= sec_w ? 8'h00 : bcd_inc(live_q[sbrtc_pkg::REG_SEC]);
                if (sec_w) begin
                    live_q[sbrtc_pkg::REG_MIN] <= min_w ? 8'h00
                        : bcd_inc(live_q[sbrtc_pkg::REG_MIN]);
                end
                if (min_w) begin
                    live_q[sbrtc_pkg::REG_HOUR][5:0] <= hr_w ? 6'h00
                        : 6'(bcd_inc({2'h0, live_q[sbrtc_pkg::REG_HOUR][5:0]}));
                end
                if (hr_w) begin
                    live_q[sbrtc_pkg::REG_DAY]  <= day_w ? 8'h01
                                                 : bcd_inc(live_q[sbrtc_pkg::REG_DAY]);
                    live_q[sbrtc_pkg::REG_DATE] <= date_w ? 8'h01
                                                 : bcd_inc(live_q[sbrtc_pkg::REG_DATE]);
                end
                if (date_w) begin
                    live_q[sbrtc_pkg::REG_MONTH] <= mon_w ? 8'h01
                        : bcd_inc(live_q[sbrtc_pkg::REG_MONTH]);
                end
                if (mon_w) begin
                    live_q[sbrtc_pkg::REG_YEAR] <= yr_w ? 8'h00
                        : bcd_inc(live_q[sbrtc_pkg::REG_YEAR]);
                end
                if (yr_w && live_q[sbrtc_pkg::REG_HOUR][sbrtc_pkg::HOUR_CEB_BIT]) begin
                    live_q[sbrtc_pkg::REG_HOUR][sbrtc_pkg::HOUR_CB_BIT] <=
                        ~live_q[sbrtc_pkg::REG_HOUR][sbrtc_pkg::HOUR_CB_BIT];
                end
            end
            if (wr_en) begin
                live_q[ptr_q] <= sh_q;
            end
        end
    end

    // User copies follow the counters except while a clock register is addressed.
    always_ff @(posedge I_CLOCK or posedge I_RESET) begin
        if (I_RESET) begin
            for (int i = 0; i < sbrtc_pkg::REG_COUNT; i++) begin
                user_q[i] <= sbrtc_pkg::RESET_ZERO;
            end
            frozen_q <= 1'b0;
        end else begin
            frozen_q <= active_q && ptr_q <= sbrtc_pkg::REG_YEAR;
            if (!frozen_q) begin
                for (int i = 0; i < sbrtc_pkg::REG_COUNT; i++) begin
                    user_q[i] <= live_q[i];
                end
            end
        end
    end

    // Bus slave sequencer.
    always_ff @(posedge I_CLOCK or posedge I_RESET) begin
        if (I_RESET) begin
            state_q  <= sbrtc_pkg::SQ_IDLE;
            kind_q   <= sbrtc_pkg::K_ADDR;
            cnt_q    <= 4'h0;
            sh_q     <= 8'h00;
            tx_q     <= 8'h00;
            ptr_q    <= 3'h0;
            rw_q     <= 1'b0;
            active_q <= 1'b0;
            O_SDA_OE <= 1'b0;
        end else if (pf_q) begin
            state_q  <= sbrtc_pkg::SQ_IDLE;
            ptr_q    <= 3'h0;
            active_q <= 1'b0;
            O_SDA_OE <= 1'b0;
        end else if (stop_c) begin
            state_q  <= sbrtc_pkg::SQ_IDLE;
            active_q <= 1'b0;
            O_SDA_OE <= 1'b0;
        end else if (start_c) begin
            state_q  <= sbrtc_pkg::SQ_RX;
            kind_q   <= sbrtc_pkg::K_ADDR;
            cnt_q    <= 4'h0;
            O_SDA_OE <= 1'b0;
        end else begin
            unique case (state_q)
                sbrtc_pkg::SQ_IDLE: begin
                    O_SDA_OE <= 1'b0;
                end
                sbrtc_pkg::SQ_RX: begin
                    if (scl_rise) begin
                        sh_q  <= {sh_q[6:0], sda_m_q[1]};
                        cnt_q <= cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == sbrtc_pkg::BIT_COUNT) begin
                        if (kind_q != sbrtc_pkg::K_ADDR
                            || sh_q[7:1] == sbrtc_pkg::SLAVE_ADDR7) begin
                            state_q  <= sbrtc_pkg::SQ_ACK_OUT;
                            O_SDA_OE <= 1'b1;
                        end else begin
                            state_q <= sbrtc_pkg::SQ_IDLE;
                        end
                        if (kind_q == sbrtc_pkg::K_ADDR) begin
                            rw_q     <= sh_q[0];
                            active_q <= sh_q[7:1] == sbrtc_pkg::SLAVE_ADDR7;
                        end
                        if (kind_q == sbrtc_pkg::K_PTR) begin
                            ptr_q <= sh_q[2:0];
                        end
                    end
                end
                sbrtc_pkg::SQ_ACK_OUT: begin
                    if (scl_fall) begin
                        cnt_q <= 4'h0;
                        if (kind_q == sbrtc_pkg::K_ADDR && rw_q) begin
                            state_q  <= sbrtc_pkg::SQ_TX;
                            tx_q     <= user_q[ptr_q];
                            O_SDA_OE <= !user_q[ptr_q][7];
                        end else begin
                            state_q  <= sbrtc_pkg::SQ_RX;
                            O_SDA_OE <= 1'b0;
                            kind_q   <= (kind_q == sbrtc_pkg::K_ADDR) ? sbrtc_pkg::K_PTR
                                                                      : sbrtc_pkg::K_DATA;
                            if (kind_q == sbrtc_pkg::K_DATA) begin
                                ptr_q <= ptr_q + 3'h1;
                            end
                        end
                    end
                end
                sbrtc_pkg::SQ_TX: begin
                    if (scl_fall) begin
                        cnt_q <= cnt_q + 4'h1;
                        tx_q  <= {tx_q[6:0], 1'b0};
                        if (cnt_q == sbrtc_pkg::BIT_COUNT - 4'h1) begin
                            state_q  <= sbrtc_pkg::SQ_ACK_IN;
                            O_SDA_OE <= 1'b0;
                        end else begin
                            O_SDA_OE <= !tx_q[6];
                        end
                    end
                end
                sbrtc_pkg::SQ_ACK_IN: begin
                    if (scl_rise) begin
                        rw_q  <= !sda_m_q[1];
                        ptr_q <= ptr_q + 3'h1;
                    end else if (scl_fall) begin
                        cnt_q <= 4'h0;
                        if (rw_q) begin
                            state_q  <= sbrtc_pkg::SQ_TX;
                            tx_q     <= user_q[ptr_q];
                            O_SDA_OE <= !user_q[ptr_q][7];
                        end else begin
                            state_q <= sbrtc_pkg::SQ_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Open-drain output: square wave at 0.5 Hz (seconds bit 0) in test mode, else the level bit.
    always_ff @(posedge I_CLOCK or posedge I_RESET) begin
        if (I_RESET) begin
            O_FREQ_PIN_OE <= 1'b0;
            O_ON_BACKUP   <= 1'b0;
        end else begin
            O_FREQ_PIN_OE <= live_q[sbrtc_pkg::REG_CAL][sbrtc_pkg::CAL_FREQ_BIT]
                             ? !live_q[sbrtc_pkg::REG_SEC][0]
                             : !live_q[sbrtc_pkg::REG_CAL][sbrtc_pkg::CAL_OUT_BIT];
            O_ON_BACKUP   <= pf_q;
        end
    end

    assign O_SDA_OUT      = 1'b0;
    assign O_FREQ_PIN_OUT = 1'b0;

    property p_ft_low;
        @(posedge I_CLOCK) disable iff (I_RESET)
        !live_q[sbrtc_pkg::REG_CAL][7] && !live_q[sbrtc_pkg::REG_CAL][6]
        |=> O_FREQ_PIN_OE && !O_FREQ_PIN_OUT;
    endproperty
    a_ft_low: assert property (p_ft_low) else $error("output pin not pulled low");

    property p_pf_abort;
        @(posedge I_CLOCK) disable iff (I_RESET)
        pf_q |=> state_q == sbrtc_pkg::SQ_IDLE && ptr_q == 3'h0 && !O_SDA_OE && O_ON_BACKUP;
    endproperty
    a_pf_abort: assert property (p_pf_abort) else $error("power fail did not abort bus");

    property p_ack_step;
        @(posedge I_CLOCK) disable iff (I_RESET)
        state_q == sbrtc_pkg::SQ_ACK_IN && scl_rise && !pf_q && !stop_c && !start_c
        |=> ptr_q == $past(ptr_q) + 3'h1;
    endproperty
    a_ack_step: assert property (p_ack_step) else $error("pointer missed read step");

    property p_wrap;
        @(posedge I_CLOCK) disable iff (I_RESET)
        ptr_q == 3'h7 && state_q == sbrtc_pkg::SQ_ACK_IN && scl_rise
        && !pf_q && !stop_c && !start_c
        |=> ptr_q == 3'h0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("pointer did not wrap");

    property p_data_bits;
        @(posedge I_CLOCK) disable iff (I_RESET)
        state_q == sbrtc_pkg::SQ_RX && kind_q == sbrtc_pkg::K_DATA && scl_rise && !pf_q
        && !stop_c && !start_c |=> $stable(ptr_q);
    endproperty
    a_data_bits: assert property (p_data_bits) else $error("pointer moved on a data bit");

    property p_addr_miss;
        @(posedge I_CLOCK) disable iff (I_RESET)
        wr_en == 1'b0 && state_q == sbrtc_pkg::SQ_RX && kind_q == sbrtc_pkg::K_ADDR && scl_fall
        && cnt_q == 4'h8 && sh_q[7:1] != 7'h68 && !pf_q && !stop_c && !start_c
        |=> state_q == sbrtc_pkg::SQ_IDLE && !O_SDA_OE;
    endproperty
    a_addr_miss: assert property (p_addr_miss) else $error("answered a foreign address");

    property p_frozen;
        @(posedge I_CLOCK) disable iff (I_RESET)
        frozen_q |=> user_q[0] == $past(user_q[0]) && user_q[6] == $past(user_q[6]);
    endproperty
    a_frozen: assert property (p_frozen) else $error("user copy moved while frozen");

    property p_follow;
        @(posedge I_CLOCK) disable iff (I_RESET)
        !frozen_q |=> user_q[0] == $past(live_q[0]);
    endproperty
    a_follow: assert property (p_follow) else $error("user copy did not follow");

    property p_sec_roll;
        @(posedge I_CLOCK) disable iff (I_RESET)
        tick && sec_w && !wr_en |=> live_q[0] == 8'h00 ##1 live_q[0] == 8'h00;
    endproperty
    a_sec_roll: assert property (p_sec_roll) else $error("seconds did not roll over");

    property p_backup_count;
        @(posedge I_CLOCK) disable iff (I_RESET)
        pf_q && tick && live_q[0] == 8'h09 |=> live_q[0] == 8'h10;
    endproperty
    a_backup_count: assert property (p_backup_count) else $error("no BCD count on backup");

    property p_feb_leap;
        @(posedge I_CLOCK) disable iff (I_RESET)
        tick && hr_w && !wr_en && live_q[5] == 8'h02 && live_q[4] == 8'h28 && live_q[6] == 8'h24
        |=> live_q[4] == 8'h29;
    endproperty
    a_feb_leap: assert property (p_feb_leap) else $error("leap day skipped");

    property p_hour_roll;
        @(posedge I_CLOCK) disable iff (I_RESET)
        tick && hr_w && !wr_en |=> live_q[2][5:0] == 6'h00 && live_q[3] != $past(live_q[3]);
    endproperty
    a_hour_roll: assert property (p_hour_roll) else $error("24-hour rollover wrong");

    property p_ack_drive;
        @(posedge I_CLOCK) disable iff (I_RESET)
        state_q == sbrtc_pkg::SQ_ACK_OUT |-> O_SDA_OE && !O_SDA_OUT;
    endproperty
    a_ack_drive: assert property (p_ack_drive) else $error("acknowledge not driven");
endmodule : sbrtc_core

// >>> test/sbrtc_bus_master.sv
// Purpose: Behavioural two-wire bus master that drives the clock core's serial port.
// Assumes: The data line is resolved outside with a pull-up; this model only pulls it low.
// Notes:   One bit takes four quarters of 625 ns, which is 400 kHz on the bus clock.
module sbrtc_bus_master (
    output logic      o_scl,
    output logic      o_sda_oe,
    input  wire logic i_sda
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int QUARTER = 625;

    initial begin
        o_scl    = 1'b1;
        o_sda_oe = 1'b0;
    end

    // Raises both lines first when the clock is low, giving a repeated start.
    task automatic start();
        if (!o_scl) begin
            o_sda_oe = 1'b0;
            #QUARTER;
            o_scl = 1'b1;
            #QUARTER;
        end
        o_sda_oe = 1'b1;
        #QUARTER;
        o_scl = 1'b0;
        #QUARTER;
    endtask : start

    task automatic stop();
        o_sda_oe = 1'b1;
        #QUARTER;
        o_scl = 1'b1;
        #QUARTER;
        o_sda_oe = 1'b0;
        #QUARTER;
    endtask : stop

    // Data changes only while the clock is low and is sampled mid-high.
    task automatic bit_io(input logic b, output logic s);
        o_sda_oe = ~b;
        #QUARTER;
        o_scl = 1'b1;
        #QUARTER;
        s = i_sda;
        #QUARTER;
        o_scl = 1'b0;
        #QUARTER;
    endtask : bit_io

    task automatic write_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], s);
        end
        bit_io(1'b1, s);
        ack = ~s;
    endtask : write_byte

    task automatic read_byte(input logic ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            b[i] = s;
        end
        bit_io(~ack, s);
    endtask : read_byte
endmodule : sbrtc_bus_master

// >>> test/serial_bcd_rtc_core_test.sv
// Purpose: Self-checking bench of the clock core seen through its bus and pins.
// Assumes: Crystal divider shortened to 4, so one second lasts 500 ns.
// Notes:   Expected calendar values follow from the bytes written and the elapsed time.
module serial_bcd_rtc_core_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int         LIMIT = 80000;
    localparam logic [7:0] WR    = {sbrtc_pkg::SLAVE_ADDR7, 1'b0};
    localparam logic [7:0] RD    = {sbrtc_pkg::SLAVE_ADDR7, 1'b1};
    logic       clk, rst, xtal, scl, m_oe, sda, sda_out, sda_oe, pin_out, pin_oe, pfail, backup;
    logic       ack;
    logic [7:0] rd;
    int         errors, compares, cycles;

    assign sda = (m_oe | (sda_oe & ~sda_out)) ? 1'b0 : 1'b1;

    sbrtc_core #(.XTAL_DIV(4)) i_sbrtc_core (
        .I_CLOCK(clk), .I_RESET(rst), .I_XTAL_CLOCK(xtal), .I_SCL(scl), .I_SDA_IN(sda),
        .O_SDA_OUT(sda_out), .O_SDA_OE(sda_oe), .O_FREQ_PIN_OUT(pin_out), .O_FREQ_PIN_OE(pin_oe),
        .I_POWER_FAIL(pfail), .O_ON_BACKUP(backup));
    sbrtc_bus_master i_sbrtc_bus_master (.o_scl(scl), .o_sda_oe(m_oe), .i_sda(sda));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        xtal = 1'b0;
        #17;
        forever #62.5 xtal = ~xtal;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic send(input logic [7:0] b, input logic exp_ack);
        i_sbrtc_bus_master.write_byte(b, ack);
        check({7'h00, ack}, {7'h00, exp_ack});
    endtask : send

    task automatic point(input logic [7:0] ptr);
        i_sbrtc_bus_master.start();
        send(WR, 1'b1);
        send(ptr, 1'b1);
    endtask : point

    task automatic print_verdict();
        $display("counts: %0d compares, %0d errors", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict

    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            $display("run cut short after %0d cycles", cycles);
            print_verdict();
        end
    end

    task automatic test_reset();
        check({3'h0, sda_out, pin_oe, pin_out, sda_oe, backup}, 8'h00);
        $display("test reset done");
    endtask : test_reset

    // Sets 23:59 on 28 Feb of a leap year; minutes go last, reached by wrapping.
    task automatic test_leap_write();
        logic [7:0] w [8] = '{8'h23, 8'h01, 8'h28, 8'h02, 8'h24, 8'h00, 8'h00, 8'h59};
        point(8'h02);
        foreach (w[i]) begin
            send(w[i], 1'b1);
        end
        i_sbrtc_bus_master.stop();
        check({6'h00, pin_oe, pin_out}, 8'h02);
        $display("test leap write done");
    endtask : test_leap_write

    // The midnight tick has passed, so day and date have moved on by one.
    task automatic test_readback();
        logic [7:0] e [5] = '{8'h02, 8'h29, 8'h02, 8'h24, 8'h00};
        point(8'h03);
        i_sbrtc_bus_master.start();
        send(RD, 1'b1);
        foreach (e[i]) begin
            i_sbrtc_bus_master.read_byte(i < 4, rd);
            check(rd, e[i]);
        end
        i_sbrtc_bus_master.stop();
        $display("test readback done");
    endtask : test_readback

    task automatic test_wrong_addr();
        logic [7:0] a [2] = '{8'hd2, 8'h50};
        foreach (a[i]) begin
            i_sbrtc_bus_master.start();
            send(a[i], 1'b0);
            i_sbrtc_bus_master.stop();
        end
        $display("test wrong address done");
    endtask : test_wrong_addr

    // A byte sent while the supply is low must neither be taken nor acknowledged.
    task automatic test_power_fail();
        point(8'h03);
        @(negedge clk) pfail = 1'b1;
        repeat (8) @(negedge clk);
        check({7'h00, backup}, 8'h01);
        send(8'h07, 1'b0);
        i_sbrtc_bus_master.stop();
        @(negedge clk) pfail = 1'b0;
        repeat (8) @(negedge clk);
        check({7'h00, backup}, 8'h00);
        point(8'h03);
        i_sbrtc_bus_master.start();
        send(RD, 1'b1);
        i_sbrtc_bus_master.read_byte(1'b0, rd);
        check(rd, 8'h02);
        i_sbrtc_bus_master.stop();
        $display("test power fail done");
    endtask : test_power_fail

    initial begin
        rst      = 1'b1;
        pfail    = 1'b0;
        errors   = 0;
        compares = 0;
        cycles   = 0;
        // The reset is asynchronous, so it clears the crystal domain without its edges.
        repeat (3) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        test_reset();
        test_leap_write();
        test_readback();
        test_wrong_addr();
        test_power_fail();
        print_verdict();
    end
endmodule : serial_bcd_rtc_core_test
